// [verilog/low_power_timer.sv]
// low-power 16-bit time / pulse counter with compare, flag and wake request
// assumes clock sources arrive as async levels; control bits are plain ports
`include "low_power_timer_map.svh"
`timescale 1ns/1ps
`default_nettype none

module low_power_timer #(
    parameter int COUNT_W = `LPT_COUNT_W,
    parameter int PRESCALE_W = `LPT_PRESCALE_W
) (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic timer_enable_bit,
    input wire logic timer_mode_select,
    input wire logic free_run_select,
    input wire logic pulse_polarity_select,
    input wire logic [`LPT_SEL_W-1:0] pulse_input_select,
    input wire logic [`LPT_SEL_W-1:0] prescale_clock_select,
    input wire logic prescale_bypass,
    input wire logic [PRESCALE_W-1:0] prescale_value,
    input wire logic [COUNT_W-1:0] compare_value,
    input wire logic interrupt_enable,
    input wire logic compare_flag_clear,
    input wire logic debug_halt,
    input wire logic comparator_output,
    input wire logic alt_pulse_pin_1,
    input wire logic alt_pulse_pin_2,
    input wire logic alt_pulse_pin_3,
    input wire logic internal_ref_clock,
    input wire logic kilohertz_osc_clock,
    input wire logic ext_32k_ref_clock,
    input wire logic osc_ext_ref_clock,
    output logic [COUNT_W-1:0] count_value,
    output logic compare_flag,
    output logic interrupt_request,
    output logic wake_request
);
    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    initial
    begin
        if (COUNT_W != `LPT_COUNT_W)
            $error("low_power_timer: counter must be 16 bits wide");
        if (PRESCALE_W != `LPT_PRESCALE_W)
            $error("low_power_timer: prescale field must be 4 bits wide");
    end

    low_power_timer_pkg::timer_mode_t mode;
    logic [3:0] clk_sync0_reg;
    logic [3:0] clk_sync1_reg;
    logic [3:0] clk_sync2_reg;
    logic [3:0] clk_sync0_next;
    logic src_level;
    logic src_prev;
    logic src_tick;
    logic [`LPT_DIV_W-1:0] div_reg;
    logic [`LPT_DIV_W-1:0] div_next;
    logic [`LPT_DIV_W-1:0] div_limit;
    logic time_tick;
    logic pulse_seen;
    logic pulse_in;
    logic [3:0] pin_raw;
    logic [3:0] pin_sync;
    logic [COUNT_W-1:0] count_reg;
    logic [COUNT_W-1:0] count_next;
    logic flag_reg;
    logic flag_next;
    logic incr;
    logic match;

    assign mode = timer_mode_select ? low_power_timer_pkg::pulse_mode
                                    : low_power_timer_pkg::time_mode;

    // ------------------------------------------------------------
    // source clock selection
    // ------------------------------------------------------------
    // every reference clock is slower than the core clock here, so it
    // is sampled as a level and its rising edge becomes a one-cycle tick
    assign clk_sync0_next = {osc_ext_ref_clock, ext_32k_ref_clock,
                             kilohertz_osc_clock, internal_ref_clock};

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            clk_sync0_reg <= 4'h0;
            clk_sync1_reg <= 4'h0;
            clk_sync2_reg <= 4'h0;
        end
        else
        begin
            clk_sync0_reg <= clk_sync0_next;
            clk_sync1_reg <= clk_sync0_reg;
            clk_sync2_reg <= clk_sync1_reg;
        end
    end

    // index by the select; the old sample comes from stage 2
    assign src_level = clk_sync1_reg[prescale_clock_select];
    assign src_prev = clk_sync2_reg[prescale_clock_select];
    assign src_tick = src_level & ~src_prev;

    // ------------------------------------------------------------
    // pulse pin synchronisers
    // ------------------------------------------------------------
    // every pin is brought onto the core clock before the source mux,
    // so the mux never passes on a level that is still settling
    assign pin_raw = {alt_pulse_pin_3, alt_pulse_pin_2,
                      alt_pulse_pin_1, comparator_output};

    for (genvar g = 0; g < 4; g++)
    begin : g_pin_sync
        logic [1:0] sync_reg;
        logic [1:0] sync_next;

        // shift the pin into a two-stage chain
        always_comb
        begin
            sync_next = {sync_reg[0], pin_raw[g]};
        end

        always_ff @(posedge clock or negedge arst_n)
        begin
            if (!arst_n)
                sync_reg <= 2'h0;
            else
                sync_reg <= sync_next;
        end

        // only the second stage leaves the chain
        assign pin_sync[g] = sync_reg[1];
    end

    // ------------------------------------------------------------
    // pulse source selection
    // ------------------------------------------------------------
    always_comb
    begin
        // select changes only while disabled, so no glitch reaches counting
        case (pulse_input_select)
            `LPT_PIN_COMPARATOR: pulse_in = pin_sync[0];
            `LPT_PIN_ALT1: pulse_in = pin_sync[1];
            `LPT_PIN_ALT2: pulse_in = pin_sync[2];
            default: pulse_in = pin_sync[3];
        endcase
    end

    pulse_input_conditioner #(
        .FILTER_W(5)
    ) u_conditioner (
        .clock(clock),
        .arst_n(arst_n),
        .clear(!timer_enable_bit),
        .pin_async(pulse_in),
        .active_low(pulse_polarity_select),
        .filter_bypass(prescale_bypass),
        .filter_len({1'b0, prescale_value}),
        .filter_tick(src_tick),
        .count_pulse(pulse_seen)
    );

    // ------------------------------------------------------------
    // prescaler: divide the selected source by 2^(value+1)
    // ------------------------------------------------------------
    assign div_limit = `LPT_DIV_W'((`LPT_DIV_W'(2) << prescale_value) - `LPT_DIV_W'(1));

    always_comb
    begin
        div_next = div_reg;
        time_tick = 1'b0;
        if (!timer_enable_bit || mode != low_power_timer_pkg::time_mode)
            div_next = '0;
        else if (debug_halt)
            div_next = div_reg; // time count frozen in debug
        else if (src_tick)
        begin
            if (prescale_bypass || div_reg == div_limit)
            begin
                time_tick = 1'b1;
                div_next = '0;
            end
            else
                div_next = div_reg + `LPT_DIV_W'(1);
        end
    end

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            div_reg <= '0;
        else
            div_reg <= div_next;
    end

    // ------------------------------------------------------------
    // counter and compare flag
    // ------------------------------------------------------------
    // pulse counting ignores debug halt; low-power modes have no input
    // here at all, so counting carries on through them
    assign incr = (mode == low_power_timer_pkg::pulse_mode) ? pulse_seen : time_tick;
    assign match = (count_reg == compare_value);

    always_comb
    begin
        count_next = count_reg;
        flag_next = flag_reg;
        if (!timer_enable_bit)
        begin
            count_next = `LPT_COUNT_RESET;
            flag_next = 1'b0;
        end
        else
        begin
            if (compare_flag_clear)
                flag_next = 1'b0; // write of 1 clears
            if (incr)
            begin
                if (match)
                begin
                    flag_next = 1'b1; // set beats clear
                    if (!free_run_select)
                        count_next = `LPT_COUNT_RESET;
                    else
                        count_next = count_reg + COUNT_W'(1);
                end
                else
                    count_next = count_reg + COUNT_W'(1); // wraps at overflow
            end
        end
    end

    // only the power-on reset and a cleared enable clear these; other system resets do not
    // reach this block, which keeps it usable as a time-of-day count
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            count_reg <= `LPT_COUNT_RESET;
            flag_reg <= 1'b0;
        end
        else
        begin
            count_reg <= count_next;
            flag_reg <= flag_next;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign count_value = count_reg;
    assign compare_flag = flag_reg;
    // level request, held while flag and enable stand
    assign interrupt_request = flag_reg & interrupt_enable;
    // purely combinational from the flag, so a wake needs no clock edge
    assign wake_request = flag_reg & interrupt_enable;
endmodule : low_power_timer

`default_nettype wire

// [pkg/low_power_timer_map.svh]
// constants of the low-power timer: field codes, widths, counts
// assumes inclusion by bare name from design and bench files
//
// Functional notes
// - The timer counts either prescaled time ticks (divide by a power of two) or glitch-filtered input pulses.
// - When the counter equals the 16-bit compare value the interrupt is raised and the counter may reset.
// - The counter either runs free or resets on every compare match.
// - An enabled compare interrupt drives a wake request that needs no bus clock to be running.
// - The pulse input select picks 00 the comparator output and 01, 10, 11 the three alternate pins.
// - The clock select picks 00 internal reference, 01 the 1 kHz clock, 10 the 32 kHz reference, 11 the oscillator.
// - Counting goes on unchanged in run, wait, stop and low-leakage modes and can end them by interrupt.
// - In debug halt pulse counting goes on while time counting holds its value.
// - Active-high polarity counts on input rise, active-low polarity counts on input fall.
// - The timer is not reset by ordinary system resets, only by its own power-on reset and its enable.
// - Clearing the enable resets all internal logic including counter and flag; setting it starts counting. The synchronisers here are not cleared.
// - The compare flag sets when enabled and the counter equals compare and increments; it clears on disable or a write of 1.
// - With free run clear the counter resets whenever the flag sets; with it set only on overflow.
`ifndef LOW_POWER_TIMER_MAP_SVH
`define LOW_POWER_TIMER_MAP_SVH

// ------------------------------------------------------------
// field codes
// ------------------------------------------------------------
`define LPT_SEL_W 2
`define LPT_PIN_COMPARATOR 2'h0
`define LPT_PIN_ALT1 2'h1
`define LPT_PIN_ALT2 2'h2
`define LPT_PIN_ALT3 2'h3
`define LPT_CLK_INTERNAL 2'h0
`define LPT_CLK_KILOHERTZ 2'h1
`define LPT_CLK_EXT32K 2'h2
`define LPT_CLK_OSC 2'h3

// ------------------------------------------------------------
// widths and reset values
// ------------------------------------------------------------
`define LPT_COUNT_W 16
`define LPT_COUNT_RESET 16'h0000
`define LPT_PRESCALE_W 4
`define LPT_DIV_W 17
`define LPT_SYNC_STAGES 2
`define LPT_FILTER_MAX 17

`endif

// [pkg/low_power_timer_pkg.sv]
// types of the low-power timer
// assumes the map header for widths
`include "low_power_timer_map.svh"

package low_power_timer_pkg;
    typedef enum logic {time_mode, pulse_mode} timer_mode_t;
    typedef logic [`LPT_COUNT_W-1:0] count_t;
endpackage : low_power_timer_pkg

// [verilog/pulse_input_conditioner.sv]
// two-stage synchroniser, glitch filter and polarity edge detector for the pulse input
// assumes a clock-domain tick input from the parent's selected clock
`include "low_power_timer_map.svh"
`timescale 1ns/1ps
`default_nettype none

module pulse_input_conditioner #(
    parameter int FILTER_W = 5
) (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic clear,
    input wire logic pin_async,
    input wire logic active_low,
    input wire logic filter_bypass,
    input wire logic [FILTER_W-1:0] filter_len,
    input wire logic filter_tick,
    output logic count_pulse
);
    initial
    begin
        if (FILTER_W < 1 || FILTER_W > 16)
            $error("pulse_input_conditioner: FILTER_W out of range");
    end

    logic [`LPT_SYNC_STAGES-1:0] sync_reg;
    logic [`LPT_SYNC_STAGES-1:0] sync_next;
    logic stable_reg;
    logic stable_next;
    logic [FILTER_W-1:0] run_reg;
    logic [FILTER_W-1:0] run_next;
    logic pulse_reg;
    logic pulse_next;
    logic level;

    // ------------------------------------------------------------
    // synchroniser and filter
    // ------------------------------------------------------------
    // stage 0 only feeds stage 1; everything else reads stage 1
    always_comb
    begin
        sync_next = {sync_reg[0], pin_async};
        level = sync_reg[1] ^ active_low;
        stable_next = stable_reg;
        run_next = run_reg;
        pulse_next = 1'b0;
        if (clear)
        begin
            stable_next = level; // track the idle level, so enable brings no false edge
            run_next = '0;
        end
        else if (level == stable_reg)
            run_next = '0;
        else if (filter_bypass || (filter_tick && run_reg >= filter_len))
        begin
            // level held long enough: accept it
            stable_next = level;
            run_next = '0;
            pulse_next = level; // asserted edge in active sense
        end
        else if (filter_tick)
            run_next = run_reg + FILTER_W'(1);
    end

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sync_reg <= '0;
            stable_reg <= 1'b0;
            run_reg <= '0;
            pulse_reg <= 1'b0;
        end
        else
        begin
            sync_reg <= sync_next;
            stable_reg <= stable_next;
            run_reg <= run_next;
            pulse_reg <= pulse_next;
        end
    end

    assign count_pulse = pulse_reg;
endmodule : pulse_input_conditioner

`default_nettype wire

// [tb/low_power_timer_props.sv]
// port assertions of the low-power timer
// assumes a bind from the bench top file
`timescale 1ns/1ps
`default_nettype none
module low_power_timer_props #(
    parameter int COUNT_W = 16
) (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic timer_enable_bit,
    input wire logic timer_mode_select,
    input wire logic free_run_select,
    input wire logic debug_halt,
    input wire logic interrupt_enable,
    input wire logic compare_flag_clear,
    input wire logic [COUNT_W-1:0] compare_value,
    input wire logic [COUNT_W-1:0] count_value,
    input wire logic compare_flag,
    input wire logic interrupt_request,
    input wire logic wake_request
);
    // ----
    // checks
    // ----
    default clocking @(posedge clock); endclocking
    default disable iff (!arst_n);
    AST_IRQ_LEVEL: assert property (interrupt_request == (compare_flag && interrupt_enable))
        else $error("request not flag and enable");
    AST_WAKE_LEVEL: assert property (wake_request == interrupt_request)
        else $error("wake differs from request");
    AST_DISABLE_CLEARS: assert property (!timer_enable_bit |=> count_value == '0 && !compare_flag)
        else $error("disable did not clear");
    // a count only steps by one or drops to zero
    AST_STEP: assert property (timer_enable_bit && $past(timer_enable_bit) && $changed(count_value)
        |-> count_value == $past(count_value) + 1'b1 || count_value == '0) else $error("bad count step");
    AST_FLAG_CAUSE: assert property ($rose(compare_flag) |-> $past(count_value) == compare_value)
        else $error("flag without match");
    AST_MATCH_RESET: assert property ($rose(compare_flag) && !free_run_select |-> count_value == '0)
        else $error("no reset on match");
    AST_FLAG_HOLD: assert property (compare_flag && timer_enable_bit && !compare_flag_clear |=> compare_flag)
        else $error("flag dropped");
    // no set can happen when the count is off compare, so a clear must win
    AST_FLAG_CLEAR: assert property (compare_flag_clear && count_value != compare_value |=> !compare_flag)
        else $error("flag not cleared");
    AST_HALT_HOLD: assert property (timer_enable_bit && $past(timer_enable_bit) && !timer_mode_select
        && debug_halt && $past(debug_halt) |-> $stable(count_value)) else $error("time count moved in halt");
endmodule : low_power_timer_props
`default_nettype wire

// [tb/pulse_source_model.sv]
// pulse pins, comparator output and reference clocks for the timer
// assumes the bench sets the pin levels; clocks run free
`timescale 1ns/1ps
`default_nettype none
module pulse_source_model (
    input wire logic [3:0] pin_level,
    output logic [3:0] pin_out,
    output logic [3:0] ref_clock
);
    initial pin_out = 4'h0;
    initial ref_clock = 4'h0;
    // each level lasts over three core cycles, as the timer needs
    always #173 ref_clock[0] = ~ref_clock[0];
    always #411 ref_clock[1] = ~ref_clock[1];
    always #257 ref_clock[2] = ~ref_clock[2];
    always #319 ref_clock[3] = ~ref_clock[3];
    // skew keeps pin edges off the core clock grid
    always @(pin_level) pin_out <= #17 pin_level;
endmodule : pulse_source_model
`default_nettype wire

// [tb/low_power_timer_test.sv]
// self-checking bench of the low-power timer
// assumes the timer, its map header, the source model and the checker
`include "low_power_timer_map.svh"
`timescale 1ns/1ps
`default_nettype none
`define CHECK(a, b) begin n_compared++; if ((a) !== (b)) begin miscompares++; \
    $display("[ERR] t=%0t got %h exp %h", $time, (a), (b)); end end
module low_power_timer_test;
    logic clock, arst_n, en, mode, free_run, pol, bypass, ie, clr, halt;
    logic [1:0] psel, csel;
    logic [3:0] pv, pins, pin_out, refc;
    logic [15:0] cmp, count_value, seen;
    logic flag, irq, wake;
    logic [31:0] seed;
    int miscompares, n_compared, expv;
    low_power_timer uut (.clock(clock), .arst_n(arst_n), .timer_enable_bit(en), .timer_mode_select(mode),
        .free_run_select(free_run), .pulse_polarity_select(pol), .pulse_input_select(psel),
        .prescale_clock_select(csel), .prescale_bypass(bypass), .prescale_value(pv), .compare_value(cmp),
        .interrupt_enable(ie), .compare_flag_clear(clr), .debug_halt(halt), .comparator_output(pin_out[0]),
        .alt_pulse_pin_1(pin_out[1]), .alt_pulse_pin_2(pin_out[2]), .alt_pulse_pin_3(pin_out[3]),
        .internal_ref_clock(refc[0]), .kilohertz_osc_clock(refc[1]), .ext_32k_ref_clock(refc[2]),
        .osc_ext_ref_clock(refc[3]), .count_value(count_value), .compare_flag(flag),
        .interrupt_request(irq), .wake_request(wake));
    pulse_source_model src (.pin_level(pins), .pin_out(pin_out), .ref_clock(refc));
    // ----
    // helpers
    // ----
    initial
    begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next
    // source edges in the 82200 ns window, after the prescaler divide
    function automatic int expect_ticks(input logic [1:0] sel, input logic byp, input logic [3:0] v);
        int half_ns[4] = '{173, 411, 257, 319};
        return (82200 / (2 * half_ns[sel])) >> (byp ? 0 : int'(v) + 1);
    endfunction : expect_ticks
    task automatic cyc(input int n);
        repeat (n) @(negedge clock);
    endtask : cyc
    // selected pin high then low, other pins toggle as noise
    task automatic pulse(input int n);
        for (int i = 0; i < n; i++)
        begin
            seed = lfsr_next(seed);
            pins = (seed[3:0] & ~(4'h1 << psel)) | (4'h1 << psel);
            cyc(6);
            pins = seed[7:4] & ~(4'h1 << psel);
            cyc(6);
        end
    endtask : pulse
    // settings change only while disabled
    task automatic setup(input logic m, input logic [1:0] ps, input logic p, input logic [15:0] c, input logic fr);
        mode = m;
        psel = ps;
        pol = p;
        cmp = c;
        free_run = fr;
        pins = 4'h0;
        cyc(6);
        en = 1'b1;
    endtask : setup
    task automatic end_test(input string name);
        en = 1'b0;
        cyc(2);
        `CHECK({flag, count_value}, 17'h00000)
        $display("test %s done", name);
    endtask : end_test
    task automatic give_verdict;
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : give_verdict
    // ----
    // scenarios
    // ----
    initial
    begin
        {arst_n, en, mode, free_run, pol, bypass, ie, clr, halt} = 9'h000;
        {psel, csel, pv, pins, cmp} = 28'h0000000;
        seed = 32'h0001400C;
        miscompares = 0;
        n_compared = 0;
        cyc(16);
        arst_n = 1'b1;
        // time counting from each reference, then two prescale ratios
        for (int k = 0; k < 6; k++)
        begin
            csel = (k < 4) ? k[1:0] : 2'h1;
            bypass = (k < 4);
            pv = (k == 5) ? 4'h1 : 4'h0;
            setup(1'b0, 2'h0, 1'b0, 16'hFFFF, 1'b1);
            cyc(1644);
            expv = expect_ticks(csel, bypass, pv);
            `CHECK(count_value >= expv - 2 && count_value <= expv + 2, 1'b1)
            halt = 1'b1;
            cyc(2);
            seen = count_value;
            cyc(100);
            `CHECK(count_value, seen)
            halt = 1'b0;
            end_test("time");
        end
        // every input and polarity; a random halt must not stop pulse counting
        bypass = 1'b1; // filter off, six-cycle levels must all count
        for (int k = 0; k < 8; k++)
        begin
            seed = lfsr_next(seed);
            halt = seed[8] | k[0];
            expv = 1 + int'(seed[10:9]);
            setup(1'b1, k[1:0], k[2], 16'hFFFF, 1'b1);
            pulse(expv);
            pins = 4'h1 << psel;
            cyc(8);
            `CHECK(count_value, 16'(expv + (k[2] ? 0 : 1)))
            halt = 1'b0;
            end_test("pulse");
        end
        // filter on: a short glitch is dropped, a long level counts once
        bypass = 1'b0;
        csel = 2'h1;
        pv = 4'h1;
        setup(1'b1, 2'h3, 1'b0, 16'hFFFF, 1'b1);
        pins = 4'h8;
        cyc(6);
        pins = 4'h0;
        cyc(40);
        pins = 4'h8;
        cyc(60);
        `CHECK(count_value, 16'h0001)
        end_test("filter");
        bypass = 1'b1;
        // reset on match, request, then clear
        ie = 1'b1;
        setup(1'b1, 2'h1, 1'b0, 16'h0003, 1'b0);
        pulse(3);
        `CHECK({flag, count_value}, 17'h00003)
        pulse(1);
        `CHECK({flag, irq, wake, count_value}, 19'h70000)
        clr = 1'b1;
        cyc(1);
        clr = 1'b0;
        cyc(1);
        `CHECK({flag, irq}, 2'h0)
        pulse(4);
        `CHECK({flag, count_value}, 17'h10000)
        end_test("match");
        // free run passes compare, mask drops the request, reset mid-run
        setup(1'b1, 2'h2, 1'b0, 16'h0002, 1'b1);
        pulse(3);
        `CHECK({flag, count_value}, 17'h10003)
        ie = 1'b0;
        cyc(1);
        `CHECK({flag, irq}, 2'h2)
        arst_n = 1'b0;
        cyc(1);
        `CHECK({flag, count_value}, 17'h00000)
        arst_n = 1'b1;
        end_test("reset");
        give_verdict();
    end
endmodule : low_power_timer_test
bind low_power_timer low_power_timer_props #(.COUNT_W(COUNT_W)) chk (.clock, .arst_n, .timer_enable_bit,
    .timer_mode_select, .free_run_select, .debug_halt, .interrupt_enable, .compare_flag_clear, .compare_value,
    .count_value, .compare_flag, .interrupt_request, .wake_request);
`default_nettype wire
